// ---- logic/power_mode_and_int_flags.sv ----
// Power mode sequencing, clock selects and interrupt request flags with an APB slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "power_mode_regs.svh"

module power_mode_and_int_flags
  import power_mode_pkg::*;
#(
  parameter int ADDR_W = 18
)(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // CPU core events and control bits from other registers
  input  wire logic              sleep_exec,
  input  wire logic              wake_event,
  input  wire logic              soft_standby_bit,
  input  wire logic              low_speed_on_bit,
  input  wire logic              timer_clock_source_bit,
  // Clock inputs as enables, timer counter
  input  wire logic              watch_tick,
  input  wire logic [7:0]        timer_b1_count,
  // External interrupt pins
  input  wire logic [7:0]        ext_irq_pins,
  input  wire logic              ext_irq_input_three,
  // Mode and clock outputs
  output power_mode_e            cpu_mode,
  output logic                   sub_cpu_tick,
  output logic                   sample_tick,
  // Interrupt requests
  output logic [7:0]             ext_irq_req,
  output logic                   timer_b1_irq_req,
  output logic                   direct_transfer_irq_req,
  output logic                   ext_irq_input_three_edge_pulse
);

  // Register state
  logic [7:0]  mode_ctl_q, ext_enable_q, ext_flags_q, edge_sel_q;
  logic        dt_enable_q, ext_irq_input_three_edge_sel_q;
  logic        timer_b1_overflow_flag_q, direct_transfer_flag_q;
  power_mode_e mode_q, mode_d;
  logic        dt_event;
  // Bus decode
  logic [15:0] reg_index;
  logic        aligned, mapped, wr_access, setup_phase, pslverr_q;
  logic        hit_mc2, hit_aux, hit_stat, hit_edge, hit_en, hit_flags;
  logic [7:0]  rd_mux, wbyte;
  logic [31:0] prdata_q;
  // Control fields
  logic        sub_clock_select_lo, sub_clock_select_hi, medium_speed_on_bit;
  logic        direct_transfer_on_bit, noise_sample_select;
  // Dividers
  logic [2:0]  sub_cnt_q, sub_term;
  logic [3:0]  noise_cnt_q, noise_term;
  logic        sub_tick_q, sample_tick_q;
  // Pin synchronisers and sampled levels
  logic [8:0]  pin_meta_q, pin_sync_q, pin_samp_q, pin_prev_q;
  logic [7:0]  ext_edge;
  logic        ext_irq_input_three_edge, ext_irq_input_three_pulse_q;
  // Timer wrap detect
  logic [7:0]  tb1_prev_q;
  logic        tb1_wrap;

  assign sub_clock_select_lo    = mode_ctl_q[`MC2_SUB_SEL_LO];
  assign sub_clock_select_hi    = mode_ctl_q[`MC2_SUB_SEL_HI];
  assign medium_speed_on_bit    = mode_ctl_q[`MC2_MEDIUM_SPEED];
  assign direct_transfer_on_bit = mode_ctl_q[`MC2_DIRECT_XFER];
  assign noise_sample_select    = mode_ctl_q[`MC2_NOISE_SEL];

  // Address decode on word index
  assign reg_index   = 16'(paddr[ADDR_W-1:2]);
  assign aligned     = (paddr[1:0] == 2'h0);
  assign hit_mc2     = aligned && (reg_index == `IDX_MODE_CONTROL_TWO);
  assign hit_aux     = aligned && (reg_index == `IDX_AUX_IRQ);
  assign hit_stat    = aligned && (reg_index == `IDX_MODE_STATUS);
  assign hit_edge    = aligned && (reg_index == `IDX_EDGE_SELECT);
  assign hit_en      = aligned && (reg_index == `IDX_EXT_IRQ_ENABLE);
  assign hit_flags   = aligned && (reg_index == `IDX_EXT_IRQ_FLAGS);
  assign mapped      = hit_mc2 | hit_aux | hit_stat | hit_edge | hit_en | hit_flags;
  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite && mapped;
  assign wbyte       = pwdata[7:0];

  // Read data selection
  always_comb
  begin
    rd_mux = 8'h00;
    if (hit_mc2)
      rd_mux = mode_ctl_q;
    else if (hit_aux)
      rd_mux = {4'h0, ext_irq_input_three_edge_sel_q, direct_transfer_flag_q,
                timer_b1_overflow_flag_q, dt_enable_q};
    else if (hit_stat)
      rd_mux = {5'h00, mode_q};
    else if (hit_edge)
      rd_mux = edge_sel_q;
    else if (hit_en)
      rd_mux = ext_enable_q;
    else if (hit_flags)
      rd_mux = ext_flags_q;
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_q  <= {24'h000000, rd_mux};
      pslverr_q <= !mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q && psel && penable;
  assign pready  = psel && penable;

  // Mode control two, reserved bits read as one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_ctl_q <= `MC2_RESET;
    else if (wr_access && hit_mc2)
      mode_ctl_q <= (wbyte & `MC2_RW_MASK) | (`MC2_RESET & ~`MC2_RW_MASK);
  end

  // External enables and edge selects
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_enable_q <= `EXT_ENABLE_RESET; // [RULE18]
      edge_sel_q   <= `EDGE_SELECT_RESET;
    end
    else
    begin
      if (wr_access && hit_en)
        ext_enable_q <= wbyte;
      if (wr_access && hit_edge)
        edge_sel_q <= wbyte;
    end
  end

  // Auxiliary enable and input three edge select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dt_enable_q     <= 1'b0;
      ext_irq_input_three_edge_sel_q <= 1'b0;
    end
    else if (wr_access && hit_aux)
    begin
      dt_enable_q     <= wbyte[`AUX_DT_ENABLE];
      ext_irq_input_three_edge_sel_q <= wbyte[`AUX_EXT_IRQ_INPUT_THREE_EDGE];
    end
  end

  // Subactive clock divider on the watch clock enable, upper bit picks /2
  assign sub_term = sub_clock_select_hi ? `SUB_TERM_DIV2 :
                    (sub_clock_select_lo ? `SUB_TERM_DIV4 : `SUB_TERM_DIV8); // [RULE3]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sub_cnt_q  <= 3'h0;
      sub_tick_q <= 1'b0;
    end
    else
    begin
      sub_tick_q <= 1'b0;
      if (watch_tick)
      begin
        if (sub_cnt_q >= sub_term)
        begin
          sub_cnt_q  <= 3'h0;
          sub_tick_q <= 1'b1; // [RULE3]
        end
        else
          sub_cnt_q <= sub_cnt_q + 3'h1;
      end
    end
  end

  assign sub_cpu_tick = sub_tick_q;

  // Noise elimination sampling divider on the system clock
  assign noise_term = noise_sample_select ? `NOISE_TERM_DIV4 : `NOISE_TERM_DIV16; // [RULE10]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      noise_cnt_q   <= 4'h0;
      sample_tick_q <= 1'b0;
    end
    else if (noise_cnt_q >= noise_term)
    begin
      noise_cnt_q   <= 4'h0;
      sample_tick_q <= 1'b1; // [RULE10]
    end
    else
    begin
      noise_cnt_q   <= noise_cnt_q + 4'h1;
      sample_tick_q <= 1'b0;
    end
  end

  assign sample_tick = sample_tick_q;

  // Two-stage synchroniser for the interrupt pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_q <= 9'h000;
      pin_sync_q <= 9'h000;
    end
    else
    begin
      pin_meta_q <= {ext_irq_input_three, ext_irq_pins};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Pins sampled at the noise rate to reject short glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_samp_q <= 9'h000;
      pin_prev_q <= 9'h000;
    end
    else if (sample_tick_q)
    begin
      pin_samp_q <= pin_sync_q;
      pin_prev_q <= pin_samp_q;
    end
  end

  // Edge detect per pin, select 0 falling and 1 rising
  genvar gi;
  for (gi = 0; gi < 8; gi++)
  begin : g_edge
    assign ext_edge[gi] = sample_tick_q &&
      (edge_sel_q[gi] ? (pin_samp_q[gi] && !pin_prev_q[gi])
                      : (!pin_samp_q[gi] && pin_prev_q[gi]));
  end
  assign ext_irq_input_three_edge = sample_tick_q &&
    (ext_irq_input_three_edge_sel_q ? (pin_samp_q[8] && !pin_prev_q[8])
                     : (!pin_samp_q[8] && pin_prev_q[8])); // [RULE17]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_irq_input_three_pulse_q <= 1'b0;
    else
      ext_irq_input_three_pulse_q <= ext_irq_input_three_edge;
  end

  assign ext_irq_input_three_edge_pulse = ext_irq_input_three_pulse_q;

  // External flags: set wins, clear only by writing zero to a set bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_flags_q <= `EXT_FLAGS_RESET;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (ext_edge[i])
          ext_flags_q[i] <= 1'b1; // [RULE15]
        else if (wr_access && hit_flags && !wbyte[i] && ext_flags_q[i])
          ext_flags_q[i] <= 1'b0; // [RULE15] [RULE16]
      end
    end
  end

  assign ext_irq_req = ext_flags_q & ext_enable_q; // [RULE18]

  // Timer counter wrap detect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tb1_prev_q <= `TB1_ZERO;
    else
      tb1_prev_q <= timer_b1_count;
  end

  assign tb1_wrap = (tb1_prev_q == `TB1_MAX) && (timer_b1_count == `TB1_ZERO); // [RULE12]

  // Timer and direct transfer flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_b1_overflow_flag_q <= 1'b0;
      direct_transfer_flag_q   <= 1'b0;
    end
    else
    begin
      if (tb1_wrap)
        timer_b1_overflow_flag_q <= 1'b1; // [RULE12]
      else if (wr_access && hit_aux && !wbyte[`AUX_TB1_FLAG] && timer_b1_overflow_flag_q)
        timer_b1_overflow_flag_q <= 1'b0; // [RULE13] [RULE16]
      if (dt_event)
        direct_transfer_flag_q <= 1'b1; // [RULE14]
      else if (wr_access && hit_aux && !wbyte[`AUX_DT_FLAG] && direct_transfer_flag_q)
        direct_transfer_flag_q <= 1'b0; // [RULE14] [RULE16]
    end
  end

  assign timer_b1_irq_req        = timer_b1_overflow_flag_q;
  assign direct_transfer_irq_req = direct_transfer_flag_q && dt_enable_q; // [RULE11]

  // Next mode on a sleep instruction or a wake event
  always_comb
  begin
    mode_d   = mode_q;
    dt_event = 1'b0;
    unique case (mode_q)
      MODE_ACTIVE_HIGH, MODE_ACTIVE_MEDIUM:
      begin
        if (sleep_exec)
        begin
          if (direct_transfer_on_bit && soft_standby_bit && timer_clock_source_bit &&
              low_speed_on_bit)
          begin
            mode_d   = MODE_SUBACTIVE; // [RULE7] [RULE8]
            dt_event = 1'b1;
          end
          else if (direct_transfer_on_bit && !soft_standby_bit && !low_speed_on_bit &&
                   (medium_speed_on_bit == (mode_q == MODE_ACTIVE_HIGH)))
          begin
            mode_d   = medium_speed_on_bit ? MODE_ACTIVE_MEDIUM
                                           : MODE_ACTIVE_HIGH; // [RULE7] [RULE8]
            dt_event = 1'b1;
          end
          else if (soft_standby_bit)
            mode_d = timer_clock_source_bit ? MODE_WATCH : MODE_STANDBY; // [RULE2] [RULE6]
          else
            mode_d = medium_speed_on_bit ? MODE_SLEEP_MEDIUM : MODE_SLEEP_HIGH; // [RULE1] [RULE5]
        end
      end
      MODE_SUBACTIVE:
      begin
        if (sleep_exec)
        begin
          if (direct_transfer_on_bit && soft_standby_bit && timer_clock_source_bit &&
              !low_speed_on_bit)
          begin
            mode_d   = medium_speed_on_bit ? MODE_ACTIVE_MEDIUM : MODE_ACTIVE_HIGH; // [RULE9]
            dt_event = 1'b1;
          end
          else if (soft_standby_bit)
            mode_d = MODE_WATCH; // [RULE2] [RULE6]
          else
            mode_d = MODE_SUBSLEEP; // [RULE1] [RULE6]
        end
      end
      MODE_SLEEP_HIGH, MODE_SLEEP_MEDIUM, MODE_STANDBY, MODE_WATCH:
      begin
        if (wake_event)
          mode_d = medium_speed_on_bit ? MODE_ACTIVE_MEDIUM : MODE_ACTIVE_HIGH; // [RULE4]
      end
      MODE_SUBSLEEP:
      begin
        if (wake_event)
          mode_d = MODE_SUBACTIVE;
      end
    endcase
  end

  // Mode register; mode inputs are control bits held elsewhere
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= MODE_ACTIVE_HIGH;
    else
      mode_q <= mode_d; // [RULE19]
  end

  assign cpu_mode = mode_q;

endmodule : power_mode_and_int_flags

// ---- logic/power_mode_regs.svh ----
// Register indices, field positions, reset values and divider counts of the power mode block
//
// Contract
// RULE1 - Sleep goes to sleep or subsleep without standby
// RULE2 - Sleep with standby goes to standby or watch
// RULE3 - Subactive clock is watch clock /8, /4, /2
// RULE4 - Wake resumes high or medium speed per flag
// RULE5 - Active sleep runs at speed set by flag
// RULE6 - Without direct transfer only low-power modes reached
// RULE7 - Direct transfer from high speed to medium/subactive
// RULE8 - Direct transfer from medium speed to high/subactive
// RULE9 - Direct transfer from subactive to high/medium speed
// RULE10 - Noise sampling is oscillator /16 or /4
// RULE11 - Direct transfer enable gates its request
// RULE12 - Timer flag set on counter wrap to zero
// RULE13 - Timer flag cleared by writing zero
// RULE14 - Direct transfer flag set on transfer, write-zero clears
// RULE15 - External flags set on edge, write-zero clears
// RULE16 - Writing one never sets a request flag
// RULE17 - Input three edge bit picks falling or rising
// RULE18 - Enable gates each external request, resets zero
// RULE19 - Standby, low-speed, timer bits come from outside
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_MODE_CONTROL_TWO   16'hfff1
`define IDX_AUX_IRQ            16'hfff2
`define IDX_MODE_STATUS        16'hfff3
`define IDX_EDGE_SELECT        16'hfff4
`define IDX_EXT_IRQ_ENABLE     16'hfff6
`define IDX_EXT_IRQ_FLAGS      16'hfff9

// Mode control two fields
`define MC2_SUB_SEL_LO         0
`define MC2_SUB_SEL_HI         1
`define MC2_MEDIUM_SPEED       2
`define MC2_DIRECT_XFER        3
`define MC2_NOISE_SEL          4
`define MC2_RESET              8'he0
`define MC2_RW_MASK            8'h1f

// Auxiliary interrupt register fields
`define AUX_DT_ENABLE          0
`define AUX_TB1_FLAG           1
`define AUX_DT_FLAG            2
`define AUX_EXT_IRQ_INPUT_THREE_EDGE          3

// Reset values
`define EXT_ENABLE_RESET       8'h00
`define EXT_FLAGS_RESET        8'h00
`define EDGE_SELECT_RESET      8'h00

// Subactive divider terminal counts (divide minus one)
`define SUB_TERM_DIV8          3'h7
`define SUB_TERM_DIV4          3'h3
`define SUB_TERM_DIV2          3'h1

// Noise sampling terminal counts (divide minus one)
`define NOISE_TERM_DIV16       4'hf
`define NOISE_TERM_DIV4        4'h3

// Timer counter wrap values
`define TB1_MAX                8'hff
`define TB1_ZERO               8'h00

`endif

// ---- logic/power_mode_pkg.sv ----
// Types shared by the power mode block
package power_mode_pkg;

  // Operating and low-power modes of the CPU
  typedef enum logic [2:0] {
    MODE_ACTIVE_HIGH,
    MODE_ACTIVE_MEDIUM,
    MODE_SUBACTIVE,
    MODE_SLEEP_HIGH,
    MODE_SLEEP_MEDIUM,
    MODE_SUBSLEEP,
    MODE_STANDBY,
    MODE_WATCH
  } power_mode_e;

endpackage : power_mode_pkg

// ---- sim/power_mode_and_int_flags_properties.sv ----
// Port-level checks of mode sequencing, timer flag and subclock tick
`timescale 1ns/1ps
module power_mode_and_int_flags_properties
  import power_mode_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Core events and outside control bits
  input wire logic        sleep_exec,
  input wire logic        wake_event,
  input wire logic        soft_standby_bit,
  input wire logic        low_speed_on_bit,
  input wire logic        timer_clock_source_bit,
  // Ticks, counter and outputs
  input wire logic        watch_tick,
  input wire logic [7:0]  timer_b1_count,
  input wire power_mode_e cpu_mode,
  input wire logic        sub_cpu_tick,
  input wire logic        timer_b1_irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Mode groups
  logic act;
  logic low;
  assign act = cpu_mode inside {MODE_ACTIVE_HIGH, MODE_ACTIVE_MEDIUM};
  assign low = cpu_mode inside {MODE_SLEEP_HIGH, MODE_SLEEP_MEDIUM, MODE_STANDBY, MODE_WATCH};

  property p_sleep_plain;
    sleep_exec && act && !soft_standby_bit |=> cpu_mode inside
      {MODE_SLEEP_HIGH, MODE_SLEEP_MEDIUM, MODE_ACTIVE_HIGH, MODE_ACTIVE_MEDIUM};
  endproperty
  a_sleep_plain: assert property (p_sleep_plain)
    else $error("sleep without standby left active group");
  property p_sleep_standby;
    sleep_exec && act && soft_standby_bit && !timer_clock_source_bit |=> cpu_mode == MODE_STANDBY;
  endproperty
  a_sleep_standby: assert property (p_sleep_standby)
    else $error("sleep with standby missed standby");
  property p_sub_sleep;
    sleep_exec && cpu_mode == MODE_SUBACTIVE && !soft_standby_bit |=> cpu_mode == MODE_SUBSLEEP;
  endproperty
  a_sub_sleep: assert property (p_sub_sleep)
    else $error("subactive sleep missed subsleep");
  property p_wake_active;
    wake_event && low |=> act;
  endproperty
  a_wake_active: assert property (p_wake_active)
    else $error("wake did not resume active");
  property p_hold;
    !sleep_exec && !wake_event |=> $stable(cpu_mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode changed without event");
  property p_sub_needs_ls;
    sleep_exec && act && !low_speed_on_bit |=> cpu_mode != MODE_SUBACTIVE;
  endproperty
  a_sub_needs_ls: assert property (p_sub_needs_ls)
    else $error("subactive entered without low speed");
  property p_timer_wrap;
    $past(presetn) && $past(timer_b1_count) == 8'hff && timer_b1_count == 8'h00
      |=> timer_b1_irq_req;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap)
    else $error("timer wrap did not set flag");
  property p_sub_tick;
    sub_cpu_tick |-> $past(watch_tick);
  endproperty
  a_sub_tick: assert property (p_sub_tick)
    else $error("subclock tick without watch tick");

  // Main scenarios reached
  c_to_sub: cover property (sleep_exec && act ##1 cpu_mode == MODE_SUBACTIVE);
  c_sub_wake: cover property (wake_event && cpu_mode == MODE_SUBSLEEP);
  c_wrap: cover property (timer_b1_irq_req);
endmodule : power_mode_and_int_flags_properties

bind power_mode_and_int_flags power_mode_and_int_flags_properties u_props (
  .pclk(pclk), .presetn(presetn), .sleep_exec(sleep_exec), .wake_event(wake_event),
  .soft_standby_bit(soft_standby_bit), .low_speed_on_bit(low_speed_on_bit),
  .timer_clock_source_bit(timer_clock_source_bit), .watch_tick(watch_tick),
  .timer_b1_count(timer_b1_count), .cpu_mode(cpu_mode), .sub_cpu_tick(sub_cpu_tick),
  .timer_b1_irq_req(timer_b1_irq_req)
);

// ---- sim/cpu_core_model.sv ----
// Behavioural CPU core issuing sleep and wake events and standby control bits
`timescale 1ns/1ps
module cpu_core_model (
  // Clock
  input wire logic pclk,
  // Events and control bits
  output logic     sleep_exec = 1'b0,
  output logic     wake_event = 1'b0,
  output logic     soft_standby_bit = 1'b0,
  output logic     low_speed_on_bit = 1'b0,
  output logic     timer_clock_source_bit = 1'b0
);
  // One-cycle sleep or wake pulse
  task automatic pulse(input logic wake);
    @(posedge pclk);
    if (wake)
      wake_event <= 1'b1;
    else
      sleep_exec <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    sleep_exec <= 1'b0;
  endtask : pulse

  // Control bits held in other registers of the core
  task automatic set_bits(input logic ss, input logic ls, input logic tm);
    @(posedge pclk);
    soft_standby_bit <= ss;
    low_speed_on_bit <= ls;
    timer_clock_source_bit <= tm;
  endtask : set_bits
endmodule : cpu_core_model

// ---- sim/power_mode_and_int_flags_tb.sv ----
// Self-checking bench for the power mode and interrupt flag block
`timescale 1ns/1ps
`include "power_mode_regs.svh"
module power_mode_and_int_flags_tb
  import power_mode_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, slp, wk, ss, ls, tm, sub_tick, samp, tb_req, dt_req, p3;
  logic        watch_tick = 1'b0;
  logic        three = 1'b0;
  logic [7:0]  tcount = 8'h00;
  logic [7:0]  pins = 8'h00;
  logic [7:0]  ext_req;
  power_mode_e cpu_mode;
  int          n_fail = 0;
  int          compares = 0;

  // Clock at 50 MHz
  always #10 pclk = ~pclk;

  power_mode_and_int_flags DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(slp), .wake_event(wk), .soft_standby_bit(ss), .low_speed_on_bit(ls),
    .timer_clock_source_bit(tm), .watch_tick(watch_tick), .timer_b1_count(tcount),
    .ext_irq_pins(pins), .ext_irq_input_three(three), .cpu_mode(cpu_mode),
    .sub_cpu_tick(sub_tick), .sample_tick(samp), .ext_irq_req(ext_req),
    .timer_b1_irq_req(tb_req), .direct_transfer_irq_req(dt_req), .ext_irq_input_three_edge_pulse(p3)
  );

  cpu_core_model u_cpu (
    .pclk(pclk), .sleep_exec(slp), .wake_event(wk), .soft_standby_bit(ss),
    .low_speed_on_bit(ls), .timer_clock_source_bit(tm)
  );

  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One APB transfer with setup and access phases
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write and checked read
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] rd;
    logic       e;
    apb(1'b1, idx, d, rd, e);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    logic       e;
    apb(1'b0, idx, 8'h00, rd, e);
    chk(rd, exp, "register read");
  endtask : rdc

  // Expected mode after a sleep event
  function automatic power_mode_e nxt(power_mode_e m, logic dt, logic ms, logic s, logic l,
                                      logic t);
    if (m == MODE_SUBACTIVE)
      return (dt && s && t && !l) ? (ms ? MODE_ACTIVE_MEDIUM : MODE_ACTIVE_HIGH)
                                  : (s ? MODE_WATCH : MODE_SUBSLEEP);
    if (dt && s && t && l)
      return MODE_SUBACTIVE;
    if (dt && !s && !l && ms != (m == MODE_ACTIVE_MEDIUM))
      return ms ? MODE_ACTIVE_MEDIUM : MODE_ACTIVE_HIGH;
    if (s)
      return t ? MODE_WATCH : MODE_STANDBY;
    return ms ? MODE_SLEEP_MEDIUM : MODE_SLEEP_HIGH;
  endfunction : nxt

  // Watchdog
  initial
  begin
    #(20 * 40000);
    n_fail++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    logic [7:0]  r;
    logic [7:0]  rd;
    logic        e;
    power_mode_e m;
    power_mode_e p;
    int          n;
    void'($urandom(32'hbb63));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`IDX_MODE_CONTROL_TWO, 8'he0);
    rdc(`IDX_AUX_IRQ, 8'h00);
    rdc(`IDX_EXT_IRQ_ENABLE, 8'h00);
    rdc(`IDX_EDGE_SELECT, 8'h00);
    apb(1'b0, 16'hfff5, 8'h00, rd, e);
    chk(e, 1'b1, "unmapped error");
    wr(`IDX_EXT_IRQ_FLAGS, 8'hff);
    rdc(`IDX_EXT_IRQ_FLAGS, 8'h00);
    // Subclock and sampling dividers for every select value
    for (int s = 0; s < 4; s++)
    begin
      wr(`IDX_MODE_CONTROL_TWO, {3'b000, s[0], 2'b00, s[1:0]});
      rdc(`IDX_MODE_CONTROL_TWO, {3'b111, s[0], 2'b00, s[1:0]});
      repeat (2)
      begin
        n = 0;
        do
        begin
          @(posedge pclk) watch_tick <= 1'b1;
          @(posedge pclk) watch_tick <= 1'b0;
          n++;
          @(negedge pclk);
        end while (sub_tick !== 1'b1 && n < 20);
      end
      chk(n, s[1] ? 2 : (s[0] ? 4 : 8), "subclock divide");
      repeat (2)
      begin
        n = 0;
        do
        begin
          @(negedge pclk);
          n++;
        end while (samp !== 1'b1 && n < 40);
      end
      chk(n, s[0] ? 4 : 16, "sample rate");
    end
    // Timer wrap, write one ignored, write zero clears
    @(posedge pclk) tcount <= 8'hff;
    @(posedge pclk) tcount <= 8'h00;
    @(negedge pclk) chk(tb_req, 1'b0, "timer early");
    @(negedge pclk) chk(tb_req, 1'b1, "timer wrap");
    wr(`IDX_AUX_IRQ, 8'h02);
    rdc(`IDX_AUX_IRQ, 8'h02);
    wr(`IDX_AUX_IRQ, 8'h00);
    rdc(`IDX_AUX_IRQ, 8'h00);
    // External pin edges with random polarity and enables
    r = 8'($urandom);
    n = $urandom % 256;
    wr(`IDX_EDGE_SELECT, r);
    wr(`IDX_EXT_IRQ_ENABLE, n[7:0]);
    pins <= ~r;
    repeat (80) @(posedge pclk);
    wr(`IDX_EXT_IRQ_FLAGS, 8'h00);
    pins <= r;
    repeat (80) @(posedge pclk);
    rdc(`IDX_EXT_IRQ_FLAGS, 8'hff);
    @(negedge pclk) chk(ext_req, n[7:0], "enable gating");
    wr(`IDX_EXT_IRQ_FLAGS, 8'h0f);
    pins <= ~r;
    repeat (80) @(posedge pclk);
    rdc(`IDX_EXT_IRQ_FLAGS, 8'h0f);
    // Input three edge polarity
    for (int s = 0; s < 2; s++)
    begin
      wr(`IDX_AUX_IRQ, {4'h0, s[0], 3'b000});
      three <= ~s[0];
      repeat (80) @(posedge pclk);
      three <= s[0];
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end while (p3 !== 1'b1 && n < 80);
      chk(n < 80, 1'b1, "input three edge");
    end
    // Random sleep and wake sequencing
    m = MODE_ACTIVE_HIGH;
    repeat (80)
    begin
      r = 8'($urandom);
      wr(`IDX_MODE_CONTROL_TWO, {4'h0, r[0], r[1], 2'b00});
      wr(`IDX_AUX_IRQ, {7'h00, r[5]});
      u_cpu.set_bits(r[2], r[3], r[4]);
      u_cpu.pulse(1'b0);
      p = nxt(m, r[0], r[1], r[2], r[3], r[4]);
      @(negedge pclk) chk(cpu_mode, p, "sleep");
      chk(dt_req, (p <= MODE_SUBACTIVE) && r[5], "direct request");
      rdc(`IDX_AUX_IRQ, {5'h00, p <= MODE_SUBACTIVE, 1'b0, r[5]});
      if (p > MODE_SUBACTIVE)
      begin
        u_cpu.pulse(1'b0);
        rdc(`IDX_MODE_STATUS, {5'h00, p});
        u_cpu.pulse(1'b1);
        p = (p == MODE_SUBSLEEP) ? MODE_SUBACTIVE : (r[1] ? MODE_ACTIVE_MEDIUM : MODE_ACTIVE_HIGH);
        @(negedge pclk) chk(cpu_mode, p, "wake");
      end
      m = p;
    end
    complete_run();
  end
endmodule : power_mode_and_int_flags_tb
